// File: verif/lfatx_regs_test.sv
// Purpose: self-checking bench of the lf antenna register bank
// Assumes: mclk 10 MHz, spi half period of 5 mclk
// Notes:   the transmitter is stood in for by done pulses
`include "lfatx_defs.svh"
`default_nettype none
module lfatx_regs_test
  import lfatx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, resetn, tx_buffer_done;
  logic        spi_ncs, spi_sclk, spi_sdi, spi_sdo_out, spi_sdo_oe;
  logic        div_tick, bit_tick, tx_busy, tx_active_sel;
  lfatx_word_t tx_word, w;
  logic [15:0] out_mode;
  logic [7:0]  out_en, meas1_delay_cycles, meas2_delay_cycles;
  logic [4:0]  first_data_amplitude, second_data_amplitude;
  logic [3:0]  destroy_amplitude;
  logic [5:0]  second_data_amplitude_start_bytes, destroy_start_bits;
  logic [6:0]  second_data_amplitude_bit_count;
  logic [2:0]  destroy_len_bits, meas1_output, meas2_output;
  logic        meas1_falling, meas2_falling;
  logic [63:0] rsp;
  int          fail_count, check_count, p;

  lfatx_regs lfatx_regs_inst (.mclk, .resetn, .spi_ncs, .spi_sclk,
    .spi_sdi, .spi_sdo_out, .spi_sdo_oe, .tx_buffer_done, .div_tick,
    .bit_tick, .tx_busy, .tx_active_sel, .tx_word, .out_mode, .out_en,
    .first_data_amplitude, .second_data_amplitude, .destroy_amplitude,
    .second_data_amplitude_start_bytes, .second_data_amplitude_bit_count, .destroy_start_bits,
    .destroy_len_bits, .meas1_delay_cycles, .meas2_delay_cycles,
    .meas1_falling, .meas2_falling, .meas1_output, .meas2_output);
  lfatx_spi_master lfatx_spi_master_inst (.mclk, .spi_ncs, .spi_sclk,
    .spi_sdi, .spi_sdo_out, .spi_sdo_oe);

  // ==========================================================
  // helpers
  task test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk_val(input logic [63:0] g, e, input string m);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task chk_cnt(input int g, e, input string m);
    check_count++;
    if (g != e) begin
      fail_count++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, m, g, e);
    end
  endtask
  task clk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task frame(input logic [7:0] c, input lfatx_word_t d);
    lfatx_spi_master_inst.xfer({c, d}, 64, rsp);
  endtask
  task done_pulse;
    tx_buffer_done <= 1'b1;
    clk(1);
    tx_buffer_done <= 1'b0;
    clk(4);
  endtask
  // bounded wait on the busy level
  task wait_busy(input logic v);
    for (int i = 0; i < 200; i++) begin
      clk(1);
      if (tx_busy === v) return;
    end
    fail_count++;
    $display("[ERR] %0t busy wait timed out", $time);
    test_done();
  endtask
  // spacing of two ticks; gives up after 3000 edges
  task period(input bit bt);
    int t0;
    t0 = -1;
    p = -1;
    for (int i = 0; i < 3000 && p < 0; i++) begin
      clk(1);
      if ((bt ? bit_tick : div_tick) === 1'b1) begin
        if (t0 >= 0) p = i - t0;
        t0 = i;
      end
    end
    if (p < 0) begin
      fail_count++;
      $display("[ERR] %0t tick wait timed out", $time);
      test_done();
    end
  endtask
  function automatic lfatx_word_t cfg(input logic [1:0] dv,
    input logic bd, input logic [5:0] ds, input logic [1:0] dl,
    input logic sm, input logic sl);
    lfatx_word_t c;
    c = '0;
    c[`LFATX_F_CLKDIV]  = dv;
    c[`LFATX_F_BAUD]    = bd;
    c[`LFATX_F_OUTMODE] = 16'h1BE4; // every drive mode used
    c[`LFATX_F_FIRST_DATA_AMPLITUDE]   = 5'h1F;
    c[`LFATX_F_DGAIN]   = 4'hF;
    c[`LFATX_F_G2START] = 6'h3F;
    c[`LFATX_F_G2BITS]  = 7'h7F;
    c[`LFATX_F_DSTART]  = ds;
    c[`LFATX_F_DLEN]    = dl;
    c[`LFATX_F_SENDMODE] = sm;
    c[`LFATX_F_SLEEP]   = sl;
    return c;
  endfunction

  // ==========================================================
  // scenarios
  task t_reset;
    chk_val(out_en, 8'h00, "sleep");
    chk_val(out_mode, 16'h0000, "modes");
    chk_val(first_data_amplitude, 5'h1B, "first_data_amplitude");
    chk_val(second_data_amplitude, 5'h0D, "second_data_amplitude");
    chk_val(destroy_amplitude, 4'h9, "dgain");
    chk_val(second_data_amplitude_start_bytes, 6'h00, "g2 start");
    chk_val(second_data_amplitude_bit_count, 7'h00, "g2 bits");
    chk_val(destroy_start_bits, 6'h02, "dstart");
    chk_val(destroy_len_bits, 3'h1, "dlen");
    chk_val(tx_word, 56'h0, "buffer");
    chk_val(meas1_delay_cycles, 8'h06, "timer1");
    chk_val(meas2_delay_cycles, 8'h06, "timer2");
    chk_val(meas1_falling, 1'b0, "trig1");
    chk_val(meas2_falling, 1'b0, "trig2");
    chk_val(meas1_output, 3'h0, "sel1");
    chk_val(meas2_output, 3'h1, "sel2");
    period(0);
    chk_cnt(p, 8, "div by eight");
    frame(8'h00, '0);
    chk_val(rsp, 64'h0, "first reply");
    $display("t_reset done");
  endtask
  task t_cfg;
    for (int i = 0; i < 4; i++) begin
      frame(8'h10, cfg(i[1:0], 1'b1, i[5:0], i[1:0], 1'b1, i[0]));
      period(0);
      chk_cnt(p, 1 << i, "division");
      chk_val(destroy_len_bits, i + 1, "dlen");
      chk_val(destroy_start_bits, i < 2 ? 2 : i, "dstart");
      chk_val(out_en, i[0] ? 8'h00 : 8'hFF, "sleep");
      w = cfg(i[1:0], 1'b1, i < 2 ? 6'h02 : i[5:0], i[1:0], 1'b1, i[0]);
      frame(8'h00, '0);
      chk_val(rsp, {8'h10, w}, "readback");
    end
    chk_val(out_mode, 16'h1BE4, "modes");
    chk_val(first_data_amplitude, 5'h1F, "first_data_amplitude");
    chk_val(second_data_amplitude, 5'h00, "second_data_amplitude");
    chk_val(destroy_amplitude, 4'hF, "dgain");
    chk_val(second_data_amplitude_start_bytes, 6'h3F, "g2 start");
    chk_val(second_data_amplitude_bit_count, 7'h7F, "g2 bits");
    $display("t_cfg done");
  endtask
  task t_csr;
    w = '0;
    // accuracy set, timers inside one bit
    w[`LFATX_F_TIMER1] = 9'h003;
    w[`LFATX_F_TIMER2] = 9'h01D;
    w[46] = 1'b1;
    w[36] = 1'b1;
    w[`LFATX_F_TRIG1] = 1'b1;
    w[`LFATX_F_TRIG2] = 1'b1;
    w[`LFATX_F_SEL1] = 3'h5;
    w[`LFATX_F_SEL2] = 3'h2;
    frame(8'h20, w);
    chk_val(meas1_delay_cycles, 8'h10, "timer1");
    chk_val(meas2_delay_cycles, 8'h89, "timer2");
    chk_val(meas1_falling, 1'b1, "trig1");
    chk_val(meas2_falling, 1'b1, "trig2");
    chk_val(meas1_output, 3'h5, "sel1");
    chk_val(meas2_output, 3'h2, "sel2");
    frame(8'h80, '0);
    w[23] = 1'b1; // still asleep from the last config
    chk_val(rsp, {8'h20, w}, "csr image");
    $display("t_csr done");
  endtask
  task t_tx;
    frame(8'h10, cfg(2'h3, 1'b1, 6'h04, 2'h0, 1'b1, 1'b0));
    frame(8'h30, 56'h11223344556677);
    wait_busy(1'b1);
    period(1);
    chk_cnt(p, 597, "fast baud");
    chk_val(tx_word, 56'h11223344556677, "buf1 out");
    frame(8'h30, 56'hAAAAAAAAAAAAAA); // active buffer, dropped
    frame(8'h40, 56'h55555555555555);
    chk_val(rsp, {8'h30, 56'h11223344556677}, "buf1 kept");
    done_pulse();
    chk_val(tx_active_sel, 1'b1, "switch");
    chk_val(tx_word, 56'h55555555555555, "buf2 out");
    done_pulse();
    chk_val(tx_busy, 1'b0, "active reload refused");
    $display("t_tx done");
  endtask
  task t_start;
    frame(8'h10, cfg(2'h3, 1'b0, 6'h04, 2'h0, 1'b0, 1'b0));
    frame(8'h30, 56'h0F0F0F0F0F0F0F);
    clk(10);
    chk_val(tx_busy, 1'b0, "no auto start");
    lfatx_spi_master_inst.xfer(64'h1000000000000000, 32, rsp);
    frame(8'h70, '1); // undefined op
    chk_val(out_en, 8'hFF, "bad frames");
    chk_val(destroy_start_bits, 6'h04, "short frame");
    frame(8'h50, '0);
    wait_busy(1'b1);
    period(1);
    chk_cnt(p, 1194, "slow baud");
    chk_val(tx_word, 56'h0F0F0F0F0F0F0F, "buf1 out");
    done_pulse();
    wait_busy(1'b0);
    $display("t_start done");
  endtask

  // free-running mclk
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // reset for two cycles, then the scenarios in turn
  initial begin
    resetn = 1'b0;
    tx_buffer_done = 1'b0;
    fail_count = 0;
    check_count = 0;
    clk(2);
    resetn <= 1'b1;
    clk(10);
    t_reset();
    t_cfg();
    t_csr();
    t_tx();
    t_start();
    test_done();
  end
endmodule // lfatx_regs_test
`default_nettype wire

// File: verif/lfatx_spi_master.sv
// Purpose: spi master model for the register bank pins
// Assumes: sclk half period of 5 mclk, sclk low at ncs fall
// Notes:   sdi idles at the inverse of its last bit
`default_nettype none
module lfatx_spi_master (
  input  wire logic mclk,
  output logic      spi_ncs,
  output logic      spi_sclk,
  output logic      spi_sdi,
  input  wire logic spi_sdo_out,
  input  wire logic spi_sdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle pins at time zero
  initial begin
    spi_ncs  = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi  = 1'b0;
  end
  // ==========================================================
  // frame of n bits, msb first; sdo counts only while driven
  // sdo is taken just before sclk falls, after the device shifted it
  // command byte leads
  task automatic xfer(input logic [63:0] f, input int n,
                      output logic [63:0] r);
    r = '0;
    spi_ncs <= 1'b0;
    repeat (5) @(posedge mclk);
    for (int i = 63; i > 63 - n; i--) begin
      spi_sclk <= 1'b1;
      spi_sdi  <= f[i];
      repeat (5) @(posedge mclk);
      r[i] = spi_sdo_oe ? spi_sdo_out : 1'bx;
      spi_sclk <= 1'b0;
      repeat (5) @(posedge mclk);
    end
    spi_ncs <= 1'b1;
    spi_sdi <= ~spi_sdi; // released line must not hold its value
    repeat (8) @(posedge mclk);
  endtask
endmodule // lfatx_spi_master
`default_nettype wire

// File: verilog/lfatx_bufmem.sv
// Purpose: two transmit data words with registered read ports
// Assumes: one write per cycle
// Notes:   both words clear at reset
`include "lfatx_defs.svh"
`default_nettype none
module lfatx_bufmem (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 we,
  input  wire logic                 waddr,
  input  wire lfatx_pkg::lfatx_word_t wdata,
  input  wire logic                 raddr_a,
  output lfatx_pkg::lfatx_word_t    rdata_a,
  input  wire logic                 raddr_b,
  output lfatx_pkg::lfatx_word_t    rdata_b
);
  import lfatx_pkg::*;
  lfatx_word_t mem_reg [2];
  lfatx_word_t mem_next [2];
  lfatx_word_t rda_next;
  lfatx_word_t rdb_next;
  // ==========================================================
  // write and read selection
  always_comb begin
    mem_next[0] = mem_reg[0];
    mem_next[1] = mem_reg[1];
    if (we) begin
      mem_next[waddr] = wdata;
    end
    rda_next = mem_reg[raddr_a];
    rdb_next = mem_reg[raddr_b];
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      rdata_a    <= '0;
      rdata_b    <= '0;
    end else begin
      mem_reg[0] <= mem_next[0];
      mem_reg[1] <= mem_next[1];
      rdata_a    <= rda_next;
      rdata_b    <= rdb_next;
    end
  end
endmodule // lfatx_bufmem
`default_nettype wire

// File: verilog/lfatx_defs.svh
// Purpose: constants of the lf antenna transmit register bank
// Assumes: mclk at 10 MHz
// Notes:   fields are positions inside the 56-bit data word
`ifndef LFATX_DEFS_SVH
`define LFATX_DEFS_SVH
// ==========================================================
// frame layout
`define LFATX_FRAME_W      64
`define LFATX_DATA_W       56
`define LFATX_BIT_COUNT    7'h40
// ==========================================================
// command op codes (bits 6..4 of the command byte)
`define LFATX_OP_NOP       3'h0
`define LFATX_OP_CFG       3'h1
`define LFATX_OP_CSR       3'h2
`define LFATX_OP_BUF1      3'h3
`define LFATX_OP_BUF2      3'h4
`define LFATX_OP_START     3'h5
// ==========================================================
// drive configuration fields
`define LFATX_F_CLKDIV     55:54
`define LFATX_F_BAUD       53
`define LFATX_F_OUTMODE    52:37
`define LFATX_F_FIRST_DATA_AMPLITUDE      36:32
`define LFATX_F_SECOND_DATA_AMPLITUDE      31:27
`define LFATX_F_DGAIN      26:23
`define LFATX_F_G2START    22:17
`define LFATX_F_G2BITS     16:10
`define LFATX_F_DSTART     9:4
`define LFATX_F_DLEN       3:2
`define LFATX_F_SENDMODE   1
`define LFATX_F_SLEEP      0
`define LFATX_DSTART_MIN   6'h02
`define LFATX_CFG_RESET    56'hE0001B6C800023
// ==========================================================
// measurement control fields
`define LFATX_F_TIMER1     55:47
`define LFATX_F_TIMER2     45:37
`define LFATX_F_TRIG1      35
`define LFATX_F_TRIG2      34
`define LFATX_F_SEL1       33:31
`define LFATX_F_SEL2       30:28
`define LFATX_F_CSR_RW     55:28
`define LFATX_CSR_RESET    28'h0080201
// low five timer bits and selectors, as positions inside the 28 stored csr bits
`define LFATX_CSR_TIMER1   23:19
`define LFATX_CSR_TIMER2   13:9
`define LFATX_CSR_SEL1     5:3
`define LFATX_CSR_SEL2     2:0
// ==========================================================
// timing
`define LFATX_CLK_HZ       10000000
`define LFATX_BAUD_SLOW_CHZ 837000
`define LFATX_BAUD_FAST_CHZ 1675000
`define LFATX_TMR_BASE_PS10 23286
`define LFATX_TMR_STEP_PS10 46572
`define LFATX_PERIOD_PS10  10000
`endif

// File: verilog/lfatx_pkg.sv
// Purpose: shared types of the lf antenna transmit register bank
// Assumes: nothing
// Notes:   constants live in lfatx_defs.svh
`default_nettype none
package lfatx_pkg;
  typedef enum logic [1:0] {LFATX_IDLE, LFATX_SEND1, LFATX_SEND2}
    lfatx_mode_t;
  typedef logic [55:0] lfatx_word_t;
endpackage
`default_nettype wire

// File: verilog/lfatx_regs.sv
// Purpose: configuration, measurement and buffer registers
// Assumes: tx_buffer_done comes from mclk logic
// Notes:   loads happen at the ncs rising edge of a full frame
// Notes on behaviour
// - 64-bit shift, two 56-bit buffers, zeroed
// - clock division code: none, 2, 4, 8
// - baud bit: 8.37 or 16.75 kHz
// - two-bit drive mode per output
// - first gain code plus one volts
// - second gain same encoding, default 01101
// - destroy gain 32 over 2^(15-code)
// - bytes before switching to second gain
// - bits sent with second gain
// - destroy length one to four bits
// - auto start on buffer one, else command
// - sleep tri-states all outputs, default sleep
// - timer one delay base plus code steps
// - timer two same delay encoding
// - trigger one picks rising or falling edges
// - trigger two picks rising or falling edges
// - selector picks output for measurement one
// - op codes load cfg, csr, buffers
// - only the inactive buffer reloads
`include "lfatx_defs.svh"
`default_nettype none
module lfatx_regs (
  input  wire logic   mclk,
  input  wire logic   resetn,
  input  wire logic   spi_ncs,
  input  wire logic   spi_sclk,
  input  wire logic   spi_sdi,
  output logic        spi_sdo_out,
  output logic        spi_sdo_oe,
  input  wire logic   tx_buffer_done,
  output logic        div_tick,
  output logic        bit_tick,
  output logic        tx_busy,
  output logic        tx_active_sel,
  output lfatx_pkg::lfatx_word_t tx_word,
  output logic [15:0] out_mode,
  output logic [7:0]  out_en,
  output logic [4:0]  first_data_amplitude,
  output logic [4:0]  second_data_amplitude,
  output logic [3:0]  destroy_amplitude,
  output logic [5:0]  second_data_amplitude_start_bytes,
  output logic [6:0]  second_data_amplitude_bit_count,
  output logic [5:0]  destroy_start_bits,
  output logic [2:0]  destroy_len_bits,
  output logic [7:0]  meas1_delay_cycles,
  output logic [7:0]  meas2_delay_cycles,
  output logic        meas1_falling,
  output logic        meas2_falling,
  output logic [2:0]  meas1_output,
  output logic [2:0]  meas2_output
);
  import lfatx_pkg::*;
  localparam int BAUD_SLOW_CYC =
    (`LFATX_CLK_HZ * 100) / `LFATX_BAUD_SLOW_CHZ;
  localparam int BAUD_FAST_CYC =
    (`LFATX_CLK_HZ * 100) / `LFATX_BAUD_FAST_CHZ;

  // delay code to whole mclk cycles, rounded down
  function automatic logic [7:0] timer_cycles(input logic [4:0] code);
    int t;
    t = (`LFATX_TMR_BASE_PS10 + int'(code) * `LFATX_TMR_STEP_PS10)
        / `LFATX_PERIOD_PS10;
    return t[7:0];
  endfunction

  // ==========================================================
  // spi shifter and buffer memory
  lfatx_spi_if sbus ();
  lfatx_word_t rd_a, rd_b;
  logic        mem_we, mem_waddr;
  lfatx_spi_shift u_shift (
    .mclk        (mclk),
    .resetn      (resetn),
    .spi_ncs     (spi_ncs),
    .spi_sclk    (spi_sclk),
    .spi_sdi     (spi_sdi),
    .spi_sdo_out (spi_sdo_out),
    .spi_sdo_oe  (spi_sdo_oe),
    .bus         (sbus.shifter)
  );
  logic [7:0]  cmd_last_reg, cmd_last_next;
  lfatx_bufmem u_mem (
    .mclk    (mclk),
    .resetn  (resetn),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (sbus.frame[55:0]),
    .raddr_a (cmd_last_reg[6:4] == `LFATX_OP_BUF2),
    .rdata_a (rd_a),
    .raddr_b (tx_active_sel),
    .rdata_b (rd_b)
  );

  // ==========================================================
  // command decode
  logic [2:0] op;
  logic       cfg_we, csr_we, start_cmd;
  assign op        = sbus.frame[62:60];
  assign cfg_we    = sbus.frame_valid & (op == `LFATX_OP_CFG);
  assign csr_we    = sbus.frame_valid & (op == `LFATX_OP_CSR);
  assign start_cmd = sbus.frame_valid & (op == `LFATX_OP_START);

  // ==========================================================
  // configuration and measurement registers
  lfatx_word_t cfg_reg, cfg_next;
  logic [27:0] csr_reg, csr_next;
  always_comb begin
    cfg_next      = cfg_reg;
    csr_next      = csr_reg;
    cmd_last_next = cmd_last_reg;
    if (sbus.frame_valid) begin
      cmd_last_next = sbus.frame[63:56];
    end
    if (cfg_we) begin
      cfg_next = sbus.frame[55:0];
      if (sbus.frame[`LFATX_F_DSTART] < `LFATX_DSTART_MIN) begin
        cfg_next[`LFATX_F_DSTART] = `LFATX_DSTART_MIN;
      end
    end
    if (csr_we) begin
      csr_next = sbus.frame[`LFATX_F_CSR_RW];
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg      <= `LFATX_CFG_RESET;
      csr_reg      <= `LFATX_CSR_RESET;
      cmd_last_reg <= 8'h00;
    end else begin
      cfg_reg      <= cfg_next;
      csr_reg      <= csr_next;
      cmd_last_reg <= cmd_last_next;
    end
  end

  // ==========================================================
  // transmit sequencing and buffer ownership
  lfatx_mode_t mode_reg, mode_next;
  logic [1:0]  full_reg, full_next;
  logic        wr_buf1, wr_buf2, buf_wr_ok;
  assign wr_buf1 = sbus.frame_valid & (op == `LFATX_OP_BUF1);
  assign wr_buf2 = sbus.frame_valid & (op == `LFATX_OP_BUF2);
  assign tx_busy = (mode_reg != LFATX_IDLE);
  assign tx_active_sel = (mode_reg == LFATX_SEND2);
  assign mem_waddr = wr_buf2;
  assign buf_wr_ok = !(tx_busy && (mem_waddr == tx_active_sel));
  assign mem_we    = (wr_buf1 | wr_buf2) & buf_wr_ok;
  always_comb begin
    mode_next = mode_reg;
    full_next = full_reg;
    if (mem_we) begin
      full_next[mem_waddr] = 1'b1;
    end
    case (mode_reg)
      LFATX_IDLE: begin
        if (cfg_reg[`LFATX_F_SENDMODE] && wr_buf1) begin
          mode_next = LFATX_SEND1;
        end else if (start_cmd && full_reg[0]) begin
          mode_next = LFATX_SEND1;
        end
      end
      LFATX_SEND1: begin
        if (tx_buffer_done) begin
          full_next[0] = mem_we & ~mem_waddr;
          mode_next = full_next[1] ? LFATX_SEND2 : LFATX_IDLE;
        end
      end
      LFATX_SEND2: begin
        if (tx_buffer_done) begin
          full_next[1] = mem_we & mem_waddr;
          mode_next = full_next[0] ? LFATX_SEND1 : LFATX_IDLE;
        end
      end
      default: begin
        mode_next = LFATX_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= LFATX_IDLE;
      full_reg <= 2'h0;
    end else begin
      mode_reg <= mode_next;
      full_reg <= full_next;
    end
  end

  // ==========================================================
  // clock divider and baud rate ticks
  logic [2:0]  div_cnt_reg, div_cnt_next;
  logic [10:0] baud_cnt_reg, baud_cnt_next;
  logic [2:0]  div_last;
  logic [10:0] baud_last;
  logic        div_tick_next, bit_tick_next;
  // divide by 1, 2, 4 or 8
  assign div_last  = 3'((4'h1 << cfg_reg[`LFATX_F_CLKDIV]) - 4'h1);
  assign baud_last = cfg_reg[`LFATX_F_BAUD] ?
                     11'(BAUD_FAST_CYC - 1) : 11'(BAUD_SLOW_CYC - 1);
  always_comb begin
    div_cnt_next  = div_cnt_reg + 3'h1;
    baud_cnt_next = baud_cnt_reg + 11'h001;
    div_tick_next = 1'b0;
    bit_tick_next = 1'b0;
    // restart on a new configuration so no stale count lingers
    if (cfg_we || div_cnt_reg >= div_last) begin
      div_cnt_next  = 3'h0;
      div_tick_next = !cfg_we;
    end
    if (cfg_we || !tx_busy || baud_cnt_reg >= baud_last) begin
      baud_cnt_next = 11'h000;
      bit_tick_next = tx_busy && !cfg_we;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_reg  <= 3'h0;
      baud_cnt_reg <= 11'h000;
      div_tick     <= 1'b0;
      bit_tick     <= 1'b0;
    end else begin
      div_cnt_reg  <= div_cnt_next;
      baud_cnt_reg <= baud_cnt_next;
      div_tick     <= div_tick_next;
      bit_tick     <= bit_tick_next;
    end
  end

  // ==========================================================
  // field outputs; timer delays and tx_word registered, the rest direct
  logic [7:0] m1_next, m2_next;
  assign m1_next = timer_cycles(csr_reg[`LFATX_CSR_TIMER1]);
  assign m2_next = timer_cycles(csr_reg[`LFATX_CSR_TIMER2]);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meas1_delay_cycles <= 8'h00;
      meas2_delay_cycles <= 8'h00;
      tx_word            <= '0;
    end else begin
      meas1_delay_cycles <= m1_next;
      meas2_delay_cycles <= m2_next;
      tx_word            <= rd_b;
    end
  end
  assign out_mode = cfg_reg[`LFATX_F_OUTMODE];
  assign out_en = cfg_reg[`LFATX_F_SLEEP] ? 8'h00 : 8'hFF;
  assign first_data_amplitude  = cfg_reg[`LFATX_F_FIRST_DATA_AMPLITUDE];
  assign second_data_amplitude = cfg_reg[`LFATX_F_SECOND_DATA_AMPLITUDE];
  assign destroy_amplitude     = cfg_reg[`LFATX_F_DGAIN];
  assign second_data_amplitude_start_bytes  = cfg_reg[`LFATX_F_G2START];
  assign second_data_amplitude_bit_count    = cfg_reg[`LFATX_F_G2BITS];
  assign destroy_start_bits = cfg_reg[`LFATX_F_DSTART];
  assign destroy_len_bits   = {1'b0, cfg_reg[`LFATX_F_DLEN]} + 3'h1;
  assign meas1_falling = csr_reg[`LFATX_F_TRIG1 - 28];
  assign meas2_falling = csr_reg[`LFATX_F_TRIG2 - 28];
  assign meas1_output  = csr_reg[`LFATX_CSR_SEL1];
  assign meas2_output  = csr_reg[`LFATX_CSR_SEL2];

  // ==========================================================
  // response word for the next frame
  lfatx_word_t csr_image, resp_data;
  assign csr_image = {csr_reg, 2'b00, tx_busy, tx_active_sel,
                      cfg_reg[`LFATX_F_SLEEP], 23'h0};
  always_comb begin
    resp_data = csr_image;
    if (!cmd_last_reg[7]) begin
      case (cmd_last_reg[6:4])
        `LFATX_OP_NOP:  resp_data = '0;
        `LFATX_OP_CFG:  resp_data = cfg_reg;
        `LFATX_OP_BUF1: resp_data = rd_a;
        `LFATX_OP_BUF2: resp_data = rd_a;
        default:        resp_data = csr_image;
      endcase
    end
  end
  assign sbus.resp = {cmd_last_reg, resp_data};

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence seq_div_quiet;
    (!div_tick) [*7];
  endsequence
  sequence seq_cfg_soon;
    ##[0:6] cfg_we;
  endsequence
  AST_CFG_LOAD: assert property (
    cfg_we |=> cfg_reg[55:10] == $past(sbus.frame[55:10]))
    else $error("configuration load mismatch");
  AST_DSTART_MIN: assert property (
    destroy_start_bits >= `LFATX_DSTART_MIN)
    else $error("destroy start below two");
  AST_ACTIVE_LOCK: assert property (
    (tx_busy && mem_we) |-> mem_waddr != tx_active_sel)
    else $error("active buffer written");
  AST_AUTO_START: assert property (
    (mode_reg == LFATX_IDLE && cfg_reg[`LFATX_F_SENDMODE] && wr_buf1)
    |=> mode_reg == LFATX_SEND1 ##2 tx_word == $past(rd_b))
    else $error("auto start missing");
  AST_MANUAL_WAIT: assert property (
    (mode_reg == LFATX_IDLE && !cfg_reg[`LFATX_F_SENDMODE]
     && !start_cmd) |=> mode_reg == LFATX_IDLE)
    else $error("started without command");
  AST_SLEEP_TRI: assert property (
    $rose(cfg_reg[`LFATX_F_SLEEP]) |-> out_en == 8'h00)
    else $error("outputs driven in sleep");
  AST_DIV8: assert property (
    (div_tick && cfg_reg[`LFATX_F_CLKDIV] == 2'h3)
    |=> seq_div_quiet or seq_cfg_soon)
    else $error("divide by eight period wrong");
  AST_TIMER1: assert property (
    csr_we |=> ##1 meas1_delay_cycles ==
      timer_cycles($past(sbus.frame[51:47], 2)))
    else $error("timer one delay wrong");
endmodule // lfatx_regs
`default_nettype wire

// File: verilog/lfatx_spi_if.sv
// Purpose: frame hand-off between spi shifter and register core
// Assumes: one clock domain (mclk)
// Notes:   frame_valid and cs_fall are one-cycle pulses
`default_nettype none
interface lfatx_spi_if;
  logic [63:0] frame;
  logic        frame_valid;
  logic        cs_fall;
  logic [63:0] resp;
  modport shifter (output frame, output frame_valid, output cs_fall,
                   input resp);
  modport core    (input frame, input frame_valid, input cs_fall,
                   output resp);
endinterface
`default_nettype wire

// File: verilog/lfatx_spi_shift.sv
// Purpose: 64-bit spi shift register, slave side
// Assumes: sclk low when ncs falls; pins are asynchronous
// Notes:   frames of other than 64 bits are dropped
`include "lfatx_defs.svh"
`default_nettype none
module lfatx_spi_shift (
  input  wire logic   mclk,
  input  wire logic   resetn,
  input  wire logic   spi_ncs,
  input  wire logic   spi_sclk,
  input  wire logic   spi_sdi,
  output logic        spi_sdo_out,
  output logic        spi_sdo_oe,
  lfatx_spi_if.shifter bus
);
  import lfatx_pkg::*;
  logic [2:0]  s1_reg, s2_reg, s3_reg;
  logic [2:0]  s2_next;
  logic [63:0] sr_reg, sr_next;
  logic [6:0]  cnt_reg, cnt_next;
  logic        sdo_reg, sdo_next;
  logic        ncs_fall, ncs_rise, sck_rise, sck_fall;
  // ==========================================================
  // edges from the second and third sync stages only
  assign s2_next  = s1_reg;
  assign ncs_fall = s3_reg[2] & ~s2_reg[2];
  assign ncs_rise = ~s3_reg[2] & s2_reg[2];
  assign sck_rise = ~s2_reg[2] & ~s3_reg[1] & s2_reg[1];
  assign sck_fall = ~s2_reg[2] & s3_reg[1] & ~s2_reg[1];
  always_comb begin
    sr_next  = sr_reg;
    cnt_next = cnt_reg;
    sdo_next = sdo_reg;
    if (ncs_fall) begin
      sr_next  = bus.resp;
      cnt_next = '0;
      sdo_next = bus.resp[63];
    end else if (sck_rise) begin
      sdo_next = sr_reg[63];
    end else if (sck_fall) begin
      sr_next  = {sr_reg[62:0], s2_reg[0]};
      cnt_next = cnt_reg + 7'h01;
    end
  end
  // pins pass two flops before any logic
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_reg  <= 3'h4;
      s2_reg  <= 3'h4;
      s3_reg  <= 3'h4;
      sr_reg  <= '0;
      cnt_reg <= '0;
      sdo_reg <= 1'b0;
    end else begin
      s1_reg  <= {spi_ncs, spi_sclk, spi_sdi};
      s2_reg  <= s2_next;
      s3_reg  <= s2_reg;
      sr_reg  <= sr_next;
      cnt_reg <= cnt_next;
      sdo_reg <= sdo_next;
    end
  end
  assign bus.frame       = sr_reg;
  assign bus.frame_valid = ncs_rise & (cnt_reg == `LFATX_BIT_COUNT);
  assign bus.cs_fall     = ncs_fall;
  assign spi_sdo_out     = sdo_reg;
  assign spi_sdo_oe      = ~s3_reg[2];
endmodule // lfatx_spi_shift
`default_nettype wire
